// *** dscp_prio_cfg.svh ***
`ifndef DSCP_PRIO_CFG_SVH
`define DSCP_PRIO_CFG_SVH
// Word indices; the byte address is four times the index.
`define EN_IDX 10'h033e
`define CP_PRIO_06_07_IDX 10'h0343
`define CP_PRIO_08_09_IDX 10'h0344
`define CP_PRIO_0A_0B_IDX 10'h0345
`define CP_PRIO_0C_0D_IDX 10'h0346
`define CP_PRIO_0E_0F_IDX 10'h0347
`define CP_PRIO_10_11_IDX 10'h0348
`define CP_PRIO_12_13_IDX 10'h0349
`define CP_PRIO_14_15_IDX 10'h034a
`define CP_PRIO_16_17_IDX 10'h034b
`define CP_PRIO_18_19_IDX 10'h034c
`define CP_PRIO_1A_1B_IDX 10'h034d
`define CP_PRIO_1C_1D_IDX 10'h034e
`define CP_PRIO_1E_1F_IDX 10'h034f
`define CP_PRIO_20_21_IDX 10'h0350
`define CP_PRIO_22_23_IDX 10'h0351
// Field positions inside a table byte.
`define HI_MSB 6
`define HI_LSB 4
`define LO_MSB 2
`define LO_LSB 0
// Table geometry and reset values.
`define TBL_REGS 15
`define TBL_ENTRIES 30
`define CP_FIRST 6'h06
`define CP_LAST 6'h23
`define CP_REG_BASE 5'h03
`define PRIO_RST 3'h0
`define EN_RST 2'h0
// Bus answer codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** dscp_prio_pkg.sv ***
package dscp_prio_pkg;
  // Internal priority and received code point.
  typedef logic [2:0] prio_t;
  typedef logic [5:0] code_point_t;
  // Decoded register slot: bit 4 hit, bits 3..0 slot number.
  typedef logic [4:0] decode_t;
  typedef logic [4:0] entry_idx_t;
endpackage : dscp_prio_pkg

// *** dscp_prio_table.sv ***
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dscp_prio_cfg.svh"
// Behaviour
// - Remap off: priority is code point bits 5..3.
// - Register 0x0343 holds code points 0x07, 0x06.
// - Register 0x0344 holds code points 0x09, 0x08.
// - Register 0x0345 holds code points 0x0B, 0x0A.
// - Register 0x0346 holds code points 0x0D, 0x0C.
// - Register 0x0347 holds code points 0x0F, 0x0E.
// - Register 0x0348 holds code points 0x11, 0x10.
// - Register 0x0349 holds code points 0x13, 0x12.
// - Register 0x034A holds code points 0x15, 0x14.
// - Register 0x034B holds code points 0x17, 0x16.
// - Register 0x034C holds code points 0x19, 0x18.
// - Register 0x034D holds code points 0x1B, 0x1A.
// - Register 0x034E holds code points 0x1D, 0x1C.
// - Register 0x034F holds code points 0x1F, 0x1E.
// - Register 0x0350 holds code points 0x21, 0x20.
// - Register 0x0351 holds code points 0x23, 0x22.

module dscp_prio_table (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address channel.
  input wire logic awvalid,
  output logic awready,
  input wire logic [15:0] awaddr,
  // AXI4-Lite write data channel.
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response channel.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address channel.
  input wire logic arvalid,
  output logic arready,
  input wire logic [15:0] araddr,
  // AXI4-Lite read data channel.
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Lookup request from the classifier.
  input wire logic lookup_valid,
  input wire dscp_prio_pkg::code_point_t lookup_cp,
  // Lookup answer, one cycle after the request.
  output logic prio_valid,
  output dscp_prio_pkg::prio_t prio_value,
  output logic prio_from_table
);

  // ****************************************************
  // Address decode
  // ****************************************************

  // Maps a byte address to a register slot; slot 0 is the enable.
  function automatic dscp_prio_pkg::decode_t decode(
    input logic [15:0] a
  );
    logic [9:0] idx;
    idx = a[11:2];
    decode = 5'h00;
    if (a[15:12] == 4'h0) begin
      case (idx)
        `EN_IDX: decode = 5'h10;
        `CP_PRIO_06_07_IDX: decode = 5'h11;
        `CP_PRIO_08_09_IDX: decode = 5'h12;
        `CP_PRIO_0A_0B_IDX: decode = 5'h13;
        `CP_PRIO_0C_0D_IDX: decode = 5'h14;
        `CP_PRIO_0E_0F_IDX: decode = 5'h15;
        `CP_PRIO_10_11_IDX: decode = 5'h16;
        `CP_PRIO_12_13_IDX: decode = 5'h17;
        `CP_PRIO_14_15_IDX: decode = 5'h18;
        `CP_PRIO_16_17_IDX: decode = 5'h19;
        `CP_PRIO_18_19_IDX: decode = 5'h1a;
        `CP_PRIO_1A_1B_IDX: decode = 5'h1b;
        `CP_PRIO_1C_1D_IDX: decode = 5'h1c;
        `CP_PRIO_1E_1F_IDX: decode = 5'h1d;
        `CP_PRIO_20_21_IDX: decode = 5'h1e;
        `CP_PRIO_22_23_IDX: decode = 5'h1f;
        default: decode = 5'h00;
      endcase
    end
  endfunction : decode

  // ****************************************************
  // Write channels
  // ****************************************************

  logic awready_q;
  logic wready_q;
  logic aw_full_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [15:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic aw_fire;
  logic w_fire;
  logic wr_commit;
  logic aw_full_d;
  logic w_full_d;
  logic bvalid_d;
  dscp_prio_pkg::decode_t wr_dec;
  logic [3:0] wr_slot;
  logic wr_en;

  // Address and data are taken in either order; the commit
  // waits for both and for the previous response to drain.
  assign aw_fire = awvalid & awready_q;
  assign w_fire = wvalid & wready_q;
  assign wr_commit = aw_full_q & w_full_q & ~bvalid_q;
  assign aw_full_d = wr_commit ? 1'b0 : (aw_full_q | aw_fire);
  assign w_full_d = wr_commit ? 1'b0 : (w_full_q | w_fire);
  assign bvalid_d = wr_commit | (bvalid_q & ~bready);
  assign wr_dec = decode(awaddr_q);
  assign wr_slot = wr_dec[3:0];
  assign wr_en = wr_commit & wr_dec[4] & wlane_q;

  // Handshake state of the write side.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      bvalid_q <= bvalid_d;
    end
  end

  // Captured address, byte lane 0 and the response code.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awaddr_q <= 16'h0000;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awaddr_q <= awaddr;
      end
      if (w_fire) begin
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (wr_commit) begin
        bresp_q <= wr_dec[4] ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ****************************************************
  // Register storage
  // ****************************************************

  logic [1:0] en_q;
  dscp_prio_pkg::prio_t tbl [0:`TBL_ENTRIES-1];

  // Enable register: bit 0 turns the remap on, bit 1 is spare.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= `EN_RST;
    end else if (wr_en && (wr_slot == 4'h0)) begin
      en_q <= wbyte_q[1:0];
    end
  end

  // Fifteen table registers, two entries each; only the fields
  // are stored, so the gaps at bits 7 and 3 drop writes.
  for (genvar k = 0; k < `TBL_REGS; k++) begin : g_reg
    dscp_prio_pkg::prio_t lo_q;
    dscp_prio_pkg::prio_t hi_q;
    logic sel;
    assign sel = wr_en && (wr_slot == 4'(k + 1));
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        lo_q <= `PRIO_RST;
        hi_q <= `PRIO_RST;
      end else if (sel) begin
        lo_q <= wbyte_q[`LO_MSB:`LO_LSB];
        hi_q <= wbyte_q[`HI_MSB:`HI_LSB];
      end
    end
    assign tbl[2*k] = lo_q;
    assign tbl[2*k+1] = hi_q;
  end

  // ****************************************************
  // Read channels
  // ****************************************************

  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_fire;
  dscp_prio_pkg::decode_t rd_dec;
  logic [3:0] rd_slot;
  dscp_prio_pkg::entry_idx_t rd_tidx;
  logic [31:0] rd_tbl;
  logic [31:0] rd_word;

  // Read data select; reserved bits are forced to zero.
  assign ar_fire = arvalid & arready_q;
  assign rd_dec = decode(araddr);
  assign rd_slot = rd_dec[3:0];
  assign rd_tidx = (rd_slot == 4'h0) ? 5'h00 : {rd_slot - 4'h1, 1'b0};
  assign rd_tbl = {24'h00_0000, 1'b0, tbl[rd_tidx + 5'h01],
                   1'b0, tbl[rd_tidx]};
  assign rd_word = !rd_dec[4] ? 32'h0000_0000 :
                   (rd_slot == 4'h0) ? {30'h0000_0000, en_q} :
                   rd_tbl;

  // One read at a time; the address is refused while data waits.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_dec[4] ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************************
  // Priority lookup
  // ****************************************************

  logic [4:0] cp_reg;
  logic cp_in;
  dscp_prio_pkg::entry_idx_t cp_idx;
  dscp_prio_pkg::prio_t tbl_prio;
  logic use_tbl;
  dscp_prio_pkg::prio_t prio_d;
  logic prio_valid_q;
  dscp_prio_pkg::prio_t prio_q;
  logic from_tbl_q;

  // Halve the code point for the register, its low bit picks
  // the field; points outside this slice fall back to bits 5..3.
  assign cp_reg = lookup_cp[5:1] - `CP_REG_BASE;
  assign cp_in = (lookup_cp >= `CP_FIRST) && (lookup_cp <= `CP_LAST);
  assign cp_idx = {cp_reg[3:0], lookup_cp[0]};
  assign tbl_prio = cp_in ? tbl[cp_idx] : `PRIO_RST;
  assign use_tbl = en_q[0] & cp_in;
  assign prio_d = use_tbl ? tbl_prio : lookup_cp[5:3];

  // Registered answer, one cycle after each request.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prio_valid_q <= 1'b0;
      prio_q <= `PRIO_RST;
      from_tbl_q <= 1'b0;
    end else begin
      prio_valid_q <= lookup_valid;
      if (lookup_valid) begin
        prio_q <= prio_d;
        from_tbl_q <= use_tbl;
      end
    end
  end

  // Outputs come straight from their flip-flops.
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign prio_valid = prio_valid_q;
  assign prio_value = prio_q;
  assign prio_from_table = from_tbl_q;

  // ****************************************************
  // Checks
  // ****************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // High for the first cycle after reset release.
  logic boot_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end
  // Remap off passes bits 5..3 through.
  property p_passthru;
    lookup_valid && !en_q[0] |=>
      prio_valid && !prio_from_table &&
      prio_value == $past(lookup_cp[5:3]);
  endproperty
  a_passthru: assert property (p_passthru)
    else $error("Priority not taken from code point bits.");
  // Remap on and in slice uses the addressed entry.
  property p_table_use;
    lookup_valid && en_q[0] && cp_in |=>
      prio_from_table && prio_value == $past(tbl[cp_idx]);
  endproperty
  a_table_use: assert property (p_table_use)
    else $error("Priority not taken from the table entry.");
  // A write to the first table register lands in both fields.
  property p_first_write;
    wr_en && wr_slot == 4'h1 |=>
      tbl[0] == $past(wbyte_q[2:0]) &&
      tbl[1] == $past(wbyte_q[6:4]);
  endproperty
  a_first_write: assert property (p_first_write)
    else $error("Table write did not update both fields.");
  // A write to the last table register lands in both fields.
  property p_last_write;
    wr_en && wr_slot == 4'hf |=>
      tbl[28] == $past(wbyte_q[2:0]) &&
      tbl[29] == $past(wbyte_q[6:4]);
  endproperty
  a_last_write: assert property (p_last_write)
    else $error("Last table write did not update both fields.");
  // The enable and table fields 0, 15 and 29 are zero straight after reset.
  property p_reset_zero;
    boot_q |-> en_q == `EN_RST && tbl[0] == `PRIO_RST &&
      tbl[15] == `PRIO_RST && tbl[29] == `PRIO_RST;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Table not zero after reset.");
  // Table reads show zero in the reserved bits.
  property p_rsv_zero;
    ar_fire && rd_dec[4] && rd_slot != 4'h0 |=>
      rdata[31:8] == 24'h00_0000 && !rdata[7] && !rdata[3];
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("Reserved table bits read as one.");
  // Address and data taken together give a response two later:
  // the commit takes one cycle and the response flop another.
  sequence s_both_taken;
    aw_fire && w_fire && !bvalid_q && !aw_full_q && !w_full_q;
  endsequence
  sequence s_response;
    !bvalid ##1 !bvalid ##1 bvalid;
  endsequence
  property p_write_answer;
    s_both_taken |-> s_response;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("Write response not two cycles after taking.");
  // A read answers on the next cycle and blocks a second one.
  property p_read_answer;
    ar_fire |=> rvalid && !arready;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read data not one cycle after address.");
  // Unmapped reads give an error and zero data.
  property p_unmapped;
    ar_fire && !rd_dec[4] |=>
      rresp == `RESP_SLVERR && rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped read not answered with an error.");
  // Answers hold until taken.
  property p_hold;
    (rvalid && !rready |=> rvalid && $stable(rdata)) and
    (bvalid && !bready |=> bvalid && $stable(bresp));
  endproperty
  a_hold: assert property (p_hold)
    else $error("Answer dropped before it was taken.");
  // A write without byte lane 0 changes nothing.
  property p_no_lane;
    wr_commit && !wlane_q |=> $stable(en_q) && $stable(tbl[0]);
  endproperty
  a_no_lane: assert property (p_no_lane)
    else $error("Write without lane 0 changed a register.");

endmodule : dscp_prio_table
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dscp_prio_cfg.svh"

module testbench;
  // ****************************************************************
  // Signals and the block under test
  // ****************************************************************
  logic clk, rstn;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic lookup_valid, prio_valid, prio_from_table;
  dscp_prio_pkg::code_point_t lookup_cp;
  dscp_prio_pkg::prio_t prio_value;
  int bad_count, n_checks;
  logic [7:0] tbl [`TBL_REGS];
  logic remap_on;

  dscp_prio_table dut (
    .clk(clk), .rstn(rstn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .lookup_valid(lookup_valid), .lookup_cp(lookup_cp),
    .prio_valid(prio_valid), .prio_value(prio_value),
    .prio_from_table(prio_from_table)
  );

  // The 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Ends the run with the verdict.
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic timeout();
    bad_count++;
    $display("ERROR %0t: wait for the block timed out", $time);
    give_verdict();
  endtask : timeout

  // Byte address of table register i; the word indices are consecutive.
  function automatic logic [15:0] reg_addr(input int i);
    logic [9:0] idx;
    idx = `CP_PRIO_06_07_IDX + 10'(i);
    return {4'h0, idx, 2'b00};
  endfunction : reg_addr

  // True when a code point is answered from the table.
  function automatic logic from_tbl(input logic [5:0] cp);
    return remap_on && cp >= `CP_FIRST && cp <= `CP_LAST;
  endfunction : from_tbl

  // Expected priority, worked out from the bench's own table copy.
  function automatic logic [2:0] exp_prio(input logic [5:0] cp);
    logic [7:0] b;
    if (!from_tbl(cp)) return cp[5:3];
    b = tbl[cp[5:1] - `CP_REG_BASE];
    return cp[0] ? b[6:4] : b[2:0];
  endfunction : exp_prio

  // ****************************************************************
  // Register bus master
  // ****************************************************************
  // One write; address and data offered together, each released when taken.
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1'b1;
        check(32'(bresp), 32'(er));
      end
    end
    bready <= 1'b0;
    if (!done) timeout();
    @(posedge clk);
  endtask : axi_write

  // One read; rready is held until the data is sampled.
  task automatic axi_read(input logic [15:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1'b1;
        check(rdata, ed);
        check(32'(rresp), 32'(er));
      end
    end
    rready <= 1'b0;
    if (!done) timeout();
    @(posedge clk);
  endtask : axi_read

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every table register and the enable read zero after reset.
  task automatic reset_values();
    for (int i = 0; i < `TBL_REGS; i++) begin
      axi_read(reg_addr(i), 32'h0000_0000, `RESP_OKAY);
    end
    axi_read({4'h0, `EN_IDX, 2'b00}, 32'h0000_0000, `RESP_OKAY);
  endtask : reset_values

  // Distinct non-zero fields, upper unlike lower, in every register, so a
  // swapped field or an aliased register shows; reserved bits written as ones.
  task automatic table_write_read();
    logic [7:0] d;
    int h;
    for (int i = 0; i < `TBL_REGS; i++) begin
      h = i % 7;
      d = {1'b1, 3'(h + 1), 1'b1, 3'((h + i / 7 + 1) % 7 + 1)};
      axi_write(reg_addr(i), {24'hff_ffff, d}, 4'hf, `RESP_OKAY);
      tbl[i] = d & 8'h77;
    end
    for (int i = 0; i < `TBL_REGS; i++) begin
      axi_read(reg_addr(i), {24'h0, tbl[i]}, `RESP_OKAY);
    end
  endtask : table_write_read

  // A write without the low strobe and writes outside the table change nothing.
  task automatic strobe_and_unmapped();
    axi_write(reg_addr(0), 32'h0000_0011, 4'he, `RESP_OKAY);
    axi_read(reg_addr(0), {24'h0, tbl[0]}, `RESP_OKAY);
    axi_write(16'h1d0c, 32'h0000_0044, 4'hf, `RESP_SLVERR);
    axi_read(16'h1d0c, 32'h0000_0000, `RESP_SLVERR);
    axi_read(16'h0d08, 32'h0000_0000, `RESP_SLVERR);
    axi_write(16'h0d48, 32'h0000_0055, 4'hf, `RESP_SLVERR);
    axi_read(16'h0d48, 32'h0000_0000, `RESP_SLVERR);
    axi_read(reg_addr(0), {24'h0, tbl[0]}, `RESP_OKAY);
  endtask : strobe_and_unmapped

  // Back-to-back lookups of every code point; answers follow one cycle on.
  task automatic lookup_sweep();
    logic [5:0] prev;
    prev = 6'h00;
    for (int c = 0; c <= 64; c++) begin
      lookup_valid <= (c < 64);
      lookup_cp <= 6'(c);
      @(posedge clk);
      if (c > 0) begin
        check(32'(prio_valid), 32'h0000_0001);
        check(32'(prio_value), 32'(exp_prio(prev)));
        check(32'(prio_from_table), 32'(from_tbl(prev)));
      end
      prev = 6'(c);
    end
    @(posedge clk);
    check(32'(prio_valid), 32'h0000_0000);
  endtask : lookup_sweep

  // Remap on: spare bit is kept, higher bits dropped, table answers.
  task automatic remap_enabled();
    axi_write({4'h0, `EN_IDX, 2'b00}, 32'hffff_ffff, 4'hf, `RESP_OKAY);
    axi_read({4'h0, `EN_IDX, 2'b00}, 32'h0000_0003, `RESP_OKAY);
    remap_on = 1'b1;
    lookup_sweep();
  endtask : remap_enabled

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Resets the block, then runs every scenario in turn.
  initial begin
    rstn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    lookup_valid = 1'b0;
    lookup_cp = 6'h00;
    bad_count = 0;
    n_checks = 0;
    remap_on = 1'b0;
    for (int i = 0; i < `TBL_REGS; i++) tbl[i] = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    reset_values();
    table_write_read();
    strobe_and_unmapped();
    lookup_sweep();
    remap_enabled();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
